// [rtl/grid_driver.sv]
// serial-in shift register, latch and blanked driver outputs
// assumes host pins are synchronous to MCLK, host shift clock <= 4 MHz
//
// What this block does
// - each shift clock rising edge queues a bit unless the fifo is full; each pop moves every stage into the next one
// - serial input bit enters stage one per shift clock; one drives high
// - last stage appears on the serial output for cascading
// - latch follows the shift register while the strobe is high
// - strobe low holds the latch at the contents before the fall
// - twenty driver outputs, each from its own latch bit
// - blanking low forces all outputs low, latch and stages untouched
// - blanking defaults high; then outputs follow the latch bits
// - test defaults low; with blanking high, test high forces all outputs high
`timescale 1ns/1ns

// ============================================================
// fifo
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = bump(wr_q);
    end
    if (pop) begin
      rd_d = bump(rd_q);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    mem_q <= mem_d;
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ============================================================
// top
module grid_driver
  import grid_driver_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // host serial side
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_IN,
  output logic SHIFT_READY,
  output logic SERIAL_OUT,
  // host control
  input wire logic LATCH_STROBE,
  input wire logic OUTPUT_BLANK_N,
  input wire logic TEST_OVERRIDE,
  // display side
  output logic [STAGES-1:0] DRIVER_OUTPUTS
);
  logic sclk_q, sclk_d;
  logic [STAGES-1:0] shift_q, shift_d;
  logic [STAGES-1:0] latch_q, latch_d;
  logic [STAGES-1:0] drive_q, drive_d;
  logic rise, pop_valid, pop_ready, pop_bit;

  // ==========================================================
  // shift clock edge and bit buffer
  assign rise = SHIFT_CLK && !sclk_q;
  // shifting pauses during test so the pattern survives it
  assign pop_ready = !TEST_OVERRIDE;

  bit_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) bit_fifo_i (
    .clk(MCLK),
    .srst(SRST),
    .in_valid(rise),
    .in_ready(SHIFT_READY),
    .in_data(SERIAL_IN),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_bit)
  );

  // ==========================================================
  // next state
  always_comb begin
    sclk_d = SHIFT_CLK;
    shift_d = shift_q;
    if (pop_valid && pop_ready) begin
      shift_d = {shift_q[STAGES-2:0], pop_bit};
    end
    latch_d = latch_q;
    if (LATCH_STROBE) begin
      latch_d = shift_q;
    end
    if (!OUTPUT_BLANK_N) begin
      drive_d = ALL_LOW;
    end else if (TEST_OVERRIDE) begin
      drive_d = ALL_HIGH;
    end else begin
      drive_d = latch_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sclk_q <= 1'b0;
      shift_q <= SHIFT_RESET;
      latch_q <= LATCH_RESET;
      drive_q <= DRIVE_RESET;
    end else begin
      sclk_q <= sclk_d;
      shift_q <= shift_d;
      latch_q <= latch_d;
      drive_q <= drive_d;
    end
  end

  assign SERIAL_OUT = shift_q[STAGES-1];
  assign DRIVER_OUTPUTS = drive_q;

  // ==========================================================
  // check helpers: pops since reset and the first bit taken
  logic [4:0] pops_q, pops_d;
  logic first_q, first_d;

  // counter saturates so the end-of-chain check fires once per run
  always_comb begin
    pops_d = pops_q;
    first_d = first_q;
    if (pop_valid && pop_ready && pops_q != 5'(STAGES)) begin
      pops_d = pops_q + 5'h01;
    end
    if (pop_valid && pop_ready && pops_q == 5'h00) begin
      first_d = pop_bit;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pops_q <= 5'h00;
      first_q <= 1'b0;
    end else begin
      pops_q <= pops_d;
      first_q <= first_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  sequence s_pop;
    pop_valid && pop_ready;
  endsequence
  sequence s_blank_then_release;
    !OUTPUT_BLANK_N ##1 OUTPUT_BLANK_N && !TEST_OVERRIDE;
  endsequence

  AST_SHIFT_STEP: assert property (s_pop |=>
    shift_q == {$past(shift_q[STAGES-2:0]), $past(pop_bit)})
    else $error("shift register did not advance one stage");
  AST_SHIFT_HOLD: assert property (!(pop_valid && pop_ready) |=>
    $stable(shift_q))
    else $error("shift register moved without a bit");
  AST_SERIAL_OUT: assert property (s_pop |=>
    SERIAL_OUT == $past(shift_q[STAGES-2]))
    else $error("serial output is not the last stage");
  AST_TRANSPARENT: assert property (LATCH_STROBE |=>
    latch_q == $past(shift_q))
    else $error("latch not following shift register");
  AST_LATCH_HOLD: assert property (!LATCH_STROBE [*2] |->
    $stable(latch_q))
    else $error("latch changed while strobe low");
  AST_BLANK: assert property (!OUTPUT_BLANK_N |=>
    DRIVER_OUTPUTS == ALL_LOW)
    else $error("outputs not blanked");
  AST_BLANK_KEEP: assert property (
    !OUTPUT_BLANK_N && !LATCH_STROBE |=> $stable(latch_q))
    else $error("blanking disturbed the latch");
  AST_FOLLOW: assert property (s_blank_then_release |=>
    DRIVER_OUTPUTS == $past(latch_q))
    else $error("outputs do not follow latch after unblank");
  AST_NORMAL: assert property (OUTPUT_BLANK_N && !TEST_OVERRIDE |=>
    DRIVER_OUTPUTS == $past(latch_q))
    else $error("outputs do not show latch");
  AST_TEST_HIGH: assert property (OUTPUT_BLANK_N && TEST_OVERRIDE |=>
    DRIVER_OUTPUTS == ALL_HIGH)
    else $error("test override did not force outputs high");
  AST_FIRST_BIT: assert property (s_pop ##1 (s_pop [*7]) |=>
    shift_q[7] == $past(pop_bit, 8))
    else $error("bit did not travel one stage per shift");
  AST_FIRST_LAST: assert property (
    $rose(pops_q == 5'(STAGES)) |-> SERIAL_OUT == first_q)
    else $error("first bit not on serial output after twenty shifts");
endmodule

// [rtl/grid_driver_pkg.sv]
// constants shared by the serial latch output driver
// assumes a single 100 MHz system clock and synchronous reset
package grid_driver_pkg;
  // ==========================================================
  // structure
  localparam int STAGES = 20;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 1;
  // ==========================================================
  // reset values and forced output patterns
  localparam logic [STAGES-1:0] SHIFT_RESET = 20'h00000;
  localparam logic [STAGES-1:0] LATCH_RESET = 20'h00000;
  localparam logic [STAGES-1:0] DRIVE_RESET = 20'h00000;
  localparam logic [STAGES-1:0] ALL_HIGH = 20'hfffff;
  localparam logic [STAGES-1:0] ALL_LOW = 20'h00000;
  // ==========================================================
  // timing of the host shift clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHIFT_MIN_PERIOD_NS = 250;
  localparam int SHIFT_MIN_CYCLES =
    (SHIFT_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [testbench/grid_driver_test.sv]
// bench for the serial latch output driver
// assumes the host model drives every pin except clock and reset
`timescale 1ns/1ns
module grid_driver_test
  import grid_driver_pkg::*;
;
  logic mclk, srst, shift_clk, serial_in, latch_strobe, blank_n, test_on;
  logic shift_ready, serial_out;
  logic [STAGES-1:0] outs, w1, w2, w3;
  int err_total = 0;
  int n_checks = 0;
  grid_driver grid_driver_i (.MCLK(mclk), .SRST(srst),
    .SHIFT_CLK(shift_clk), .SERIAL_IN(serial_in),
    .SHIFT_READY(shift_ready), .SERIAL_OUT(serial_out),
    .LATCH_STROBE(latch_strobe), .OUTPUT_BLANK_N(blank_n),
    .TEST_OVERRIDE(test_on), .DRIVER_OUTPUTS(outs));
  grid_host grid_host_i (.mclk(mclk), .shift_clk(shift_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe),
    .blank_n(blank_n), .test_on(test_on));
  // ==========================================================
  // helpers
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_shift();
    w1 = 20'ha5c3f;
    grid_host_i.send_word(w1);
    grid_host_i.set_pins(1'b1, 1'b1, 1'b0);
    grid_host_i.set_pins(1'b0, 1'b1, 1'b0);
    chk(outs, w1);
    chk({19'h0, serial_out}, {19'h0, w1[19]});
  endtask
  task automatic t_hold();
    w2 = 20'h5a3c0;
    grid_host_i.send_word(w2);
    chk(outs, w1);
    grid_host_i.set_pins(1'b1, 1'b1, 1'b0);
    chk(outs, w2);
    grid_host_i.send_bit(1'b1);
    repeat (3) @(negedge mclk);
    w3 = {w2[18:0], 1'b1};
    chk(outs, w3);
    grid_host_i.set_pins(1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_ctrl();
    grid_host_i.set_pins(1'b0, 1'b0, 1'b0);
    chk(outs, ALL_LOW);
    grid_host_i.set_pins(1'b0, 1'b1, 1'b0);
    chk(outs, w3);
    grid_host_i.set_pins(1'b0, 1'b1, 1'b1);
    chk(outs, ALL_HIGH);
    grid_host_i.set_pins(1'b0, 1'b0, 1'b1);
    chk(outs, ALL_LOW);
  endtask
  // test high stalls draining, so eight bits fill the fifo
  task automatic t_fifo();
    grid_host_i.set_pins(1'b0, 1'b1, 1'b1);
    repeat (8) grid_host_i.send_bit(1'b1);
    chk({19'h0, shift_ready}, 20'h00000);
    // a ninth bit while full is lost, so no zero may appear below
    grid_host_i.send_bit(1'b0);
    chk({19'h0, shift_ready}, 20'h00000);
    grid_host_i.set_pins(1'b1, 1'b1, 1'b0);
    repeat (10) @(negedge mclk);
    chk({19'h0, shift_ready}, 20'h00001);
    chk(outs, {w3[11:0], 8'hff});
  endtask
  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    srst = 1'b1;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    t_shift();
    t_hold();
    t_ctrl();
    t_fifo();
    end_sim();
  end
  initial begin
    #60000;
    err_total++;
    end_sim();
  end
endmodule

// [testbench/grid_host.sv]
// host model: serial data, shift clock, strobe and control pins
// assumes the bench supplies mclk; pins change at its falling edge
`timescale 1ns/1ns
module grid_host (
  // clock
  input wire logic mclk,
  // pins toward the driver
  output logic shift_clk,
  output logic serial_in,
  output logic latch_strobe,
  output logic blank_n,
  output logic test_on
);
  // ==========================================================
  // defaults: pulls on blank and test, strobe and data driven
  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    blank_n = 1'b1;
    test_on = 1'b0;
  end
  // ==========================================================
  // 26 cycles a bit keeps the shift clock just under 4 MHz
  task automatic send_bit(input logic b);
    @(negedge mclk);
    serial_in = b;
    shift_clk = 1'b1;
    repeat (13) @(negedge mclk);
    shift_clk = 1'b0;
    repeat (12) @(negedge mclk);
    // data flips once hold has run out, never stays stale
    serial_in = ~b;
  endtask
  task automatic send_word(input logic [19:0] w);
    for (int i = 19; i >= 0; i--) begin
      send_bit(w[i]);
    end
  endtask
  task automatic set_pins(input logic s, input logic bl, input logic t);
    @(negedge mclk);
    latch_strobe = s;
    blank_n = bl;
    test_on = t;
    repeat (3) @(negedge mclk);
  endtask
endmodule
